// ===== logic/hpi_pkg.sv
// Package for the sixteen_bit_host_port access sequencer.
// Assumes one expansion-bus clock; all counts are in its periods.
package hpi_pkg;

    // Clock and phase-setting widths
    localparam int         CLK_PERIOD_NS   = 100;
    localparam int         SET_W           = 4;
    localparam int         DATA_W          = 16;
    localparam int         ADDR_W          = 16;

    // Least legal phase settings
    localparam logic [3:0] ADDR_SET_MIN    = 4'h2;
    localparam logic [3:0] SETUP_SET_MIN   = 4'h2;
    localparam logic [3:0] STROBE_SET_MIN  = 4'h1;

    // Reset values of the phase settings
    localparam logic [3:0] ADDR_SET_RST    = 4'h2;
    localparam logic [3:0] SETUP_SET_RST   = 4'h2;
    localparam logic [3:0] STROBE_SET_RST  = 4'h1;
    localparam logic [3:0] HOLD_SET_RST    = 4'h2;
    localparam logic [3:0] RECOV_SET_RST   = 4'h1;

    // Width of the host-wait synchroniser
    localparam int         SYNC_STAGES     = 2;

    // Access kinds: bit 1 simplex, bit 0 read
    typedef enum logic [1:0] {
        HPI_MUX_WRITE = 2'h0,
        HPI_MUX_READ  = 2'h1,
        HPI_SPX_WRITE = 2'h2,
        HPI_SPX_READ  = 2'h3
    } hpi_kind_type;

    // Phases of one access
    typedef enum logic [5:0] {
        HPI_IDLE   = 6'h01,
        HPI_ADDR   = 6'h02,
        HPI_SETUP  = 6'h04,
        HPI_STROBE = 6'h08,
        HPI_HOLD   = 6'h10,
        HPI_RECOV  = 6'h20
    } hpi_phase_type;

    // Programmed phase lengths
    typedef struct packed {
        logic [SET_W-1:0] address_phase_setting;
        logic [SET_W-1:0] setup_phase_setting;
        logic [SET_W-1:0] strobe_phase_setting;
        logic [SET_W-1:0] hold_phase_setting;
        logic [SET_W-1:0] recovery_phase_setting;
    } hpi_timing_type;

    // One access request
    typedef struct packed {
        hpi_kind_type      kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hpi_req_type;

endpackage : hpi_pkg

// ===== logic/hpi_wait_sync.sv
// Two-flop synchroniser for the host-wait pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
module hpi_wait_sync
    import hpi_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      level_out
);

    logic [SYNC_STAGES-1:0] sync_q;

    // First stage is read only by the second
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], pin_in};
        end
    end

    assign level_out = sync_q[SYNC_STAGES-1];

endmodule : hpi_wait_sync

// ===== logic/hpi_access_seq.sv
// Access sequencer driving a DSP sixteen_bit_host_port.
// Assumes the request side is on clk and host_wait_request is a raw pin.
//
// Contract
// - Four 16-bit access kinds, each phase-timed.
// - Address setting at least 2, three clocks.
// - Setup setting at least 2, three clocks.
// - Strobe setting at least 1, two clocks.
// - Stay in address or strobe while waited.
// - Host wait honoured in address, setup and strobe phases, not in hold or recovery.
// - Address phase lasts one clock past wait.
// - Setup phase lasts one clock past wait.
// - Address and chip select start together.
// - Strobe follows chip select by address plus setup length.
// - Strobe pulse lasts programmed strobe length.
// - Write data valid before strobe rises.
// - Write data held through hold phase.
// - Read data sampled at strobe end.
// - Recovery gap set by recovery setting.
// - All counts in expansion-bus clock periods.
// - Recovery setting plus one clock sets idle gap.
`timescale 1ns/1ns
module hpi_access_seq
    import hpi_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire hpi_timing_type    timing,
    input  wire hpi_req_type       req,
    input  wire logic              req_valid,
    output logic                   req_ready,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   rd_valid,
    output logic                   busy,
    output logic                   timing_error,
    input  wire logic              host_wait_request,
    output logic                   host_cs_low,
    output logic                   host_data_strobe_primary_low,
    output logic                   host_rw,
    output logic                   host_addr_strobe_low,
    output logic [ADDR_W-1:0]      host_addr,
    output logic [DATA_W-1:0]      host_data_out,
    output logic                   host_data_oe_low,
    input  wire logic [DATA_W-1:0] host_data_in
);

    hpi_phase_type    phase_q;
    hpi_phase_type    phase_d;
    hpi_req_type      cur_q;
    hpi_timing_type   tim_q;
    logic [SET_W-1:0] cnt_q;
    logic             wait_s;
    logic             stretch_q;
    logic [SET_W-1:0] lim;
    logic             done;
    logic             simplex_next;
    logic             is_read;
    logic             is_simplex;
    logic             settings_ok;

    // Host wait comes off a pin, so it is synchronised first
    hpi_wait_sync u_wait_sync (
        .clk       (clk),
        .srst      (srst),
        .pin_in    (host_wait_request),
        .level_out (wait_s)
    );

    assign is_read    = cur_q.kind[0];
    assign is_simplex = cur_q.kind[1];

    // Settings below the legal floors are refused
    assign settings_ok = (timing.address_phase_setting >= ADDR_SET_MIN)
                       && (timing.setup_phase_setting >= SETUP_SET_MIN)
                       && (timing.strobe_phase_setting >= STROBE_SET_MIN);

    assign req_ready    = (phase_q == HPI_IDLE) && settings_ok;
    assign timing_error = !settings_ok;
    assign busy         = (phase_q != HPI_IDLE);

    // Programmed length, less one, of the phase now running
    always_comb begin
        lim = '0;
        unique case (phase_q)
            HPI_IDLE:   lim = '0;
            HPI_ADDR:   lim = tim_q.address_phase_setting;
            HPI_SETUP:  lim = tim_q.setup_phase_setting;
            HPI_STROBE: lim = tim_q.strobe_phase_setting;
            HPI_HOLD:   lim = tim_q.hold_phase_setting;
            HPI_RECOV:  lim = tim_q.recovery_phase_setting;
            default:    lim = '0;
        endcase
    end

    // A phase ends once its counter has reached the setting, and not while stretched;
    // a wait carries the counter past the setting, so the test is at-or-above
    always_comb begin
        done = 1'b0;
        unique case (phase_q)
            HPI_IDLE:   done = 1'b0;
            HPI_ADDR:   done = (cnt_q >= lim) && !wait_s && !stretch_q;
            HPI_SETUP:  done = (cnt_q >= lim) && !stretch_q;
            HPI_STROBE: done = (cnt_q >= lim) && !wait_s;
            HPI_HOLD:   done = (cnt_q >= lim);
            HPI_RECOV:  done = (cnt_q >= lim);
            default:    done = 1'b0;
        endcase
    end

    // Phase order: address, setup, strobe, hold, recovery
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            HPI_IDLE:   if (req_valid && req_ready) phase_d = HPI_ADDR;
            HPI_ADDR:   if (done) phase_d = HPI_SETUP;
            HPI_SETUP:  if (done) phase_d = HPI_STROBE;
            HPI_STROBE: if (done) phase_d = HPI_HOLD;
            HPI_HOLD:   if (done) phase_d = HPI_RECOV;
            HPI_RECOV:  if (done) phase_d = HPI_IDLE;
            default:    phase_d = HPI_IDLE;              // Upset code falls back to idle
        endcase
    end

    // Phase register
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_q <= HPI_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Per-phase cycle counter, one count per bus clock
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (phase_d != phase_q) begin
            cnt_q <= '0;
        end else if (phase_q != HPI_IDLE && cnt_q != {SET_W{1'b1}}) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // One extra clock after wait drops in address or setup phase
    always_ff @(posedge clk) begin
        if (srst) begin
            stretch_q <= 1'b0;
        end else if (wait_s && (phase_q == HPI_ADDR || phase_q == HPI_SETUP)) begin
            stretch_q <= 1'b1;
        end else begin
            stretch_q <= 1'b0;
        end
    end

    // Request and settings captured at acceptance
    always_ff @(posedge clk) begin
        if (srst) begin
            cur_q <= '0;
            tim_q <= {ADDR_SET_RST, SETUP_SET_RST, STROBE_SET_RST, HOLD_SET_RST, RECOV_SET_RST};
        end else if (phase_q == HPI_IDLE && req_valid && req_ready) begin
            cur_q <= req;
            tim_q <= timing;
        end
    end

    // Chip select and address start together and hold through hold phase
    always_ff @(posedge clk) begin
        if (srst) begin
            host_cs_low          <= 1'b1;
            host_addr            <= '0;
            host_rw              <= 1'b1;
            host_addr_strobe_low <= 1'b1;
        end else begin
            host_cs_low <= !(phase_d inside {HPI_ADDR, HPI_SETUP, HPI_STROBE, HPI_HOLD});
            if (phase_q == HPI_IDLE && phase_d == HPI_ADDR) begin
                host_addr <= req.kind[1] ? req.addr : '0;
                host_rw   <= req.kind[0];
            end
            host_addr_strobe_low <= !(phase_d == HPI_ADDR && !simplex_next);
        end
    end

    // Simplex flag of whichever request owns the next cycle
    assign simplex_next = (phase_q == HPI_IDLE) ? req.kind[1] : cur_q.kind[1];

    // Data strobe active only in the strobe phase
    always_ff @(posedge clk) begin
        if (srst) begin
            host_data_strobe_primary_low <= 1'b1;
        end else begin
            host_data_strobe_primary_low <= !(phase_d == HPI_STROBE);
        end
    end

    // Data lines: address in multiplexed address phase, write data from setup through hold
    always_ff @(posedge clk) begin
        if (srst) begin
            host_data_out    <= '0;
            host_data_oe_low <= 1'b1;
        end else begin
            host_data_out    <= host_data_out;
            host_data_oe_low <= 1'b1;
            if (phase_q == HPI_IDLE && phase_d == HPI_ADDR && !req.kind[1]) begin
                host_data_out    <= req.addr;
                host_data_oe_low <= 1'b0;
            end else if (phase_d == HPI_ADDR && !is_simplex) begin
                host_data_oe_low <= 1'b0;
            end else if (!is_read && phase_d inside {HPI_SETUP, HPI_STROBE, HPI_HOLD}) begin
                host_data_out    <= cur_q.wdata;
                host_data_oe_low <= 1'b0;
            end
        end
    end

    // Read data captured as the strobe phase ends
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            if (phase_q == HPI_STROBE && done && is_read) begin
                rd_data  <= host_data_in;
                rd_valid <= 1'b1;
            end
        end
    end

endmodule : hpi_access_seq

// ===== dv/hpi_seq_sva.sv
// Checker for the host port access sequencer pins and request handshake.
// Assumes phase settings stay put while an access runs.
`timescale 1ns/1ns
module hpi_seq_sva
    import hpi_pkg::*;
(
    input wire logic           clk,
    input wire logic           srst,
    input wire hpi_timing_type timing,
    input wire logic           req_valid,
    input wire logic           req_ready,
    input wire logic           rd_valid,
    input wire logic           busy,
    input wire logic           timing_error,
    input wire logic           host_wait_request,
    input wire logic           host_cs_low,
    input wire logic           host_data_strobe_primary_low,
    input wire logic           host_rw,
    input wire logic           host_data_oe_low
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Handshake and refusal
    a_cs_on_accept: assert property (req_valid && req_ready |=> !host_cs_low)
        else $error("chip select did not follow accept");
    a_bad_refused: assert property (timing_error |-> !req_ready)
        else $error("ready with illegal settings");
    a_busy_refused: assert property (busy |-> !req_ready)
        else $error("ready while busy");
    // Phase lengths and order on the pins
    a_strobe_late: assert property ($fell(host_cs_low) |-> host_data_strobe_primary_low [*6])
        else $error("strobe too soon after chip select");
    a_strobe_width: assert property ($fell(host_data_strobe_primary_low) |-> !host_data_strobe_primary_low [*2])
        else $error("strobe pulse too short");
    a_strobe_in_cs: assert property (!host_data_strobe_primary_low |-> !host_cs_low)
        else $error("strobe outside chip select");
    a_write_hold: assert property ($rose(host_data_strobe_primary_low) && !host_rw |-> !host_data_oe_low && !host_cs_low)
        else $error("write data dropped at strobe end");
    a_wait_stalls: assert property (!host_data_strobe_primary_low && host_wait_request [*3] |=> !host_data_strobe_primary_low)
        else $error("strobe ended during wait");
    a_read_at_end: assert property (rd_valid |-> $rose(host_data_strobe_primary_low))
        else $error("read data not at strobe end");
    a_recov_gap: assert property ($rose(host_cs_low) && timing.recovery_phase_setting == 4'h0 |-> !req_ready ##1 req_ready)
        else $error("recovery gap wrong");
endmodule : hpi_seq_sva

bind hpi_access_seq hpi_seq_sva u_sva (.*);

// ===== dv/hpi_dsp_model.sv
// Behavioural DSP host port: sixteen-word store and optional wait insertion.
// Assumes the sequencer's pin outputs on the same clock.
`timescale 1ns/1ns
module hpi_dsp_model
    import hpi_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              slow,
    input  wire logic              cs_low,
    input  wire logic              ds_low,
    input  wire logic              as_low,
    input  wire logic              rw,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dout,
    output logic                   wait_req,
    output logic [DATA_W-1:0]      din
);
    logic [DATA_W-1:0] mem_q [16];
    logic [3:0]        idx_q;
    logic              mux_q;
    logic              cs_q = 1'b1;
    logic              ds_q = 1'b1;
    logic [2:0]        wait_q = 3'h0;
    initial din = 16'h5A5A;
    assign wait_req = (wait_q != 3'h0);
    // Index capture, write store, read drive, wait after each falling select or strobe
    always @(posedge clk) begin
        cs_q <= cs_low;
        ds_q <= ds_low;
        if (!cs_low && !as_low) begin
            mux_q <= 1'b1;
            idx_q <= dout[3:0];
        end else if (cs_low) begin
            mux_q <= 1'b0;
        end
        if (ds_low && !ds_q && !rw) begin
            mem_q[mux_q ? idx_q : addr[3:0]] <= dout;
        end
        din <= (!cs_low && !ds_low && rw) ? mem_q[mux_q ? idx_q : addr[3:0]] : ~din;
        if (slow && ((!cs_low && cs_q) || (!ds_low && ds_q))) begin
            wait_q <= 3'h4;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end
    end
endmodule : hpi_dsp_model

// ===== dv/tb.sv
// Self-checking bench for the host port access sequencer.
// Assumes the behavioural DSP model on the far side and a 10 MHz clock.
`timescale 1ns/1ns
module tb;
    import hpi_pkg::*;
    logic              clk = 1'b0, srst = 1'b1, req_valid = 1'b0, slow = 1'b0;
    hpi_timing_type    timing;
    hpi_req_type       req;
    logic              req_ready, rd_valid, busy, timing_error, host_wait_request, host_cs_low;
    logic              host_data_strobe_primary_low, host_rw, host_addr_strobe_low, host_data_oe_low;
    logic [ADDR_W-1:0] host_addr, a;
    logic [DATA_W-1:0] rd_data, host_data_out, host_data_in, emem [16];
    logic [31:0]       rnd = 32'h2CD9;
    hpi_timing_type    bad [3] = '{20'h12100, 20'h21100, 20'h22000};
    int                failures = 0, cmp_count = 0, cyc = 0;

    hpi_access_seq DUT (.*);
    hpi_dsp_model u_dsp (.clk(clk), .slow(slow), .cs_low(host_cs_low), .ds_low(host_data_strobe_primary_low),
        .as_low(host_addr_strobe_low), .rw(host_rw), .addr(host_addr), .dout(host_data_out),
        .wait_req(host_wait_request), .din(host_data_in));

    // Clock and hang limit
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            failures++;
            close_out;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic logic [15:0] ph(input logic [3:0] s);
        return {12'h0, s} + 16'h1;
    endfunction : ph
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic close_out;
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // One access, phase lengths counted on the pins
    task automatic xfer(input hpi_kind_type k, input logic [15:0] ad, input logic [15:0] d);
        int n;
        hpi_timing_type t;
        t = timing;
        while (req_ready !== 1'b1) tick;
        // A wait left over from a slow access must clear the synchroniser first
        while (host_wait_request !== 1'b0) tick;
        tick;
        tick;
        req = '{k, ad, d};
        req_valid = 1'b1;
        tick;
        req_valid = 1'b0;
        chk({15'h0, busy}, 16'h1);
        chk({15'h0, host_addr_strobe_low}, {15'h0, k[1]});
        if (!k[1]) chk(host_data_out, ad);
        n = 0;
        while (host_data_strobe_primary_low === 1'b1) begin n++; tick; end
        if (!slow) chk(16'(n), ph(t.address_phase_setting) + ph(t.setup_phase_setting));
        chk(host_addr, k[1] ? ad : 16'h0);
        if (!k[0]) chk(host_data_out, d);
        chk({15'h0, host_rw}, {15'h0, k[0]});
        chk({15'h0, host_data_oe_low}, {15'h0, k[0]});
        n = 0;
        while (host_data_strobe_primary_low === 1'b0) begin n++; tick; end
        if (!slow) chk(16'(n), ph(t.strobe_phase_setting));
        if (k[0]) chk(rd_valid === 1'b1 ? rd_data : ~emem[ad[3:0]], emem[ad[3:0]]);
        else chk(host_data_out, d);
        if (!k[0]) emem[ad[3:0]] = d;
        n = 0;
        while (host_cs_low === 1'b0) begin n++; tick; end
        chk(16'(n), ph(t.hold_phase_setting));
        n = 0;
        while (req_ready !== 1'b1) begin n++; tick; end
        chk(16'(n), ph(t.recovery_phase_setting));
    endtask : xfer

    initial begin
        timing = 20'h22100;
        req = '0;
        repeat (6) @(posedge clk);
        #1 srst = 1'b0;
        // Illegal settings are refused and start nothing
        for (int i = 0; i < 3; i++) begin
            timing = bad[i];
            req_valid = 1'b1;
            tick;
            chk({15'h0, timing_error}, 16'h1);
            chk({15'h0, host_cs_low}, 16'h1);
        end
        req_valid = 1'b0;
        timing = 20'h22100;
        // Write then read back, all four kinds, random settings and waits
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            if (i >= 4) timing = {3'h1, rnd[0], 3'h1, rnd[1], 1'b0, rnd[3:2], 1'b1, 2'h0, rnd[5:4], rnd[8], rnd[8], rnd[7:6]};
            slow = (i >= 8) && rnd[9];
            if (!i[0]) a = rnd[31:16];
            xfer(hpi_kind_type'(i[1:0]), a, rnd[15:0]);
        end
        // Corner: every setting at its largest, phase counter at its end point
        slow = 1'b0;
        timing = 20'hFFFFF;
        xfer(HPI_SPX_WRITE, 16'h000F, 16'hFFFF);
        xfer(HPI_SPX_READ, 16'h000F, 16'h0000);
        close_out;
    end
endmodule : tb
